/* isc_interface_setup.sv */
// Interface setup register of a 16 by 16 time-slot switch, with block fill and
// offset measure launch control.
// Assumes the bus, frame pulse, ready and done inputs come from sys_clk logic;
// only the output drive pin comes from outside and is synchronised here.
`include "isc_consts.svh"

module isc_interface_setup
  import isc_pkg::*;
(
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // Parallel register port
  input  wire isc_bus_req_type  bus_req,
  output logic [15:0]           bus_rdata,
  output logic                  bus_ack,
  // Neighbouring register and frame timing inputs
  input  wire logic             block_fill_ready,
  input  wire logic             frame_pulse,
  input  wire logic             offset_measure_done,
  // Output drive pin, asynchronous
  input  wire logic             output_drive_pin,
  // Serial lane and rate control
  output logic [15:0]           serial_out_lanes_oe,
  output isc_rate_type          serial_rate_select,
  output logic                  rate_reserved,
  // Offset measurement control
  output logic                  start_offset_measure,
  output logic                  measure_launch,
  output logic                  measure_clear,
  output logic                  measure_running,
  // Connection memory block fill
  output isc_fill_cmd_type      fill_cmd,
  output logic                  fill_finish_pulse
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [4:0]          fill_val_reg;      // Block fill value
  logic                stby_reg;          // Output standby bit
  logic                meas_reg;          // Start measure bit
  isc_rate_type        rate_reg;          // Serial rate field
  isc_fill_state_type  fill_state_reg;    // Fill sequencer
  logic [1:0]          fill_frames_reg;   // Frames seen during fill
  logic                drive_meta_reg;    // Pin sync stage one
  logic                drive_sync_reg;    // Pin sync stage two
  logic                done_prev_reg;     // Done flag history
  logic                finish_reg;        // Fill finish pulse
  logic [15:0]         lane_oe_reg;       // Lane drive enables
  logic                wr_hit;            // Write to setup register
  logic                rd_hit;            // Read of setup register
  logic                fill_start;        // Fill accepted
  logic                fill_abort;        // Fill cancelled
  logic                fill_end;          // Fill completes this cycle
  logic                lane_drive;        // Lanes should drive
  logic [15:0]         read_word;         // Register readback image

  // ----------------------------------------
  // Decode and control terms
  // ----------------------------------------
  assign wr_hit = bus_req.sel & bus_req.wr & (bus_req.addr == `ISC_ADDR_SETUP);
  assign rd_hit = bus_req.sel & ~bus_req.wr & (bus_req.addr == `ISC_ADDR_SETUP);

  // Start on any write with go set while the sequencer is idle and the feature armed
  assign fill_start = wr_hit & bus_req.wdata[`ISC_GO_BIT] & block_fill_ready
                      & (fill_state_reg == FILL_IDLE);
  // Go written low or ready dropped cancels a running fill
  assign fill_abort = (fill_state_reg == FILL_WRITE)
                      & ((wr_hit & ~bus_req.wdata[`ISC_GO_BIT]) | ~block_fill_ready);
  // Finish on the boundary closing the second full frame
  assign fill_end   = (fill_state_reg == FILL_WRITE) & ~fill_abort & frame_pulse
                      & (fill_frames_reg == 2'(`ISC_FILL_FRAMES));

  assign lane_drive = drive_sync_reg | stby_reg;

  // Readback; unused upper bits and bit ten read zero
  always_comb begin
    read_word                                      = `ISC_SETUP_RESET;
    read_word[`ISC_FILL_VAL_MSB:`ISC_FILL_VAL_LSB] = fill_val_reg;
    read_word[`ISC_GO_BIT]                         = (fill_state_reg == FILL_WRITE);
    read_word[`ISC_STBY_BIT]                       = stby_reg;
    read_word[`ISC_MEAS_BIT]                       = meas_reg;
    read_word[`ISC_RATE_MSB:`ISC_RATE_LSB]         = rate_reg;
  end

  // ----------------------------------------
  // Register fields
  // ----------------------------------------
  // Stored fields; upper bits are not stored since software keeps them zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fill_val_reg <= 5'h00;
      stby_reg     <= 1'b0;
      meas_reg     <= 1'b0;
      rate_reg     <= ISC_RATE_2M;
    end else if (wr_hit) begin
      fill_val_reg <= bus_req.wdata[`ISC_FILL_VAL_MSB:`ISC_FILL_VAL_LSB];
      stby_reg     <= bus_req.wdata[`ISC_STBY_BIT];
      meas_reg     <= bus_req.wdata[`ISC_MEAS_BIT];
      rate_reg     <= isc_rate_type'(bus_req.wdata[`ISC_RATE_MSB:`ISC_RATE_LSB]);
    end
  end

  // Bus answer one cycle after the access
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bus_ack   <= 1'b0;
      bus_rdata <= `ISC_READ_UNMAPPED;
    end else begin
      bus_ack   <= bus_req.sel;
      bus_rdata <= rd_hit ? read_word : `ISC_READ_UNMAPPED;
    end
  end

  // ----------------------------------------
  // Block fill sequencer
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fill_state_reg  <= FILL_IDLE;
      fill_frames_reg <= 2'h0;
      finish_reg      <= 1'b0;
    end else begin
      finish_reg <= fill_end;
      unique case (fill_state_reg)
        FILL_IDLE: begin
          fill_frames_reg <= 2'h0;
          if (fill_start) begin
            fill_state_reg <= FILL_WRITE;
          end
        end
        FILL_WRITE: begin
          if (fill_abort || fill_end) begin
            fill_state_reg <= FILL_IDLE;
          end else if (frame_pulse) begin
            fill_frames_reg <= fill_frames_reg + 2'h1;
          end
        end
      endcase
    end
  end

  // Fill word: value in the top five bits, the rest zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fill_cmd <= '0;
    end else begin
      fill_cmd.active <= (fill_state_reg == FILL_WRITE) ? ~(fill_abort | fill_end) : fill_start;
      fill_cmd.word   <= {(fill_start ? bus_req.wdata[`ISC_FILL_VAL_MSB:`ISC_FILL_VAL_LSB]
                                      : fill_val_reg), 11'h000};
    end
  end

  assign fill_finish_pulse = finish_reg;

  // ----------------------------------------
  // Output drive pin and lane enables
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      drive_meta_reg <= 1'b0;
      drive_sync_reg <= 1'b0;
    end else begin
      drive_meta_reg <= output_drive_pin;
      drive_sync_reg <= drive_meta_reg;
    end
  end

  // One enable flop per lane
  for (genvar lane = 0; lane < 16; lane++) begin : g_lane
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        lane_oe_reg[lane] <= 1'b0;
      end else begin
        lane_oe_reg[lane] <= lane_drive;
      end
    end
  end

  assign serial_out_lanes_oe = lane_oe_reg;
  assign serial_rate_select  = rate_reg;
  assign rate_reserved       = (rate_reg == ISC_RATE_RSV);

  // ----------------------------------------
  // Offset measurement control
  // ----------------------------------------
  // Launch on rise, clear done on fall, stop on done rise; launch wins
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      measure_launch  <= 1'b0;
      measure_clear   <= 1'b0;
      measure_running <= 1'b0;
      done_prev_reg   <= 1'b0;
    end else begin
      done_prev_reg  <= offset_measure_done;
      measure_launch <= wr_hit & bus_req.wdata[`ISC_MEAS_BIT] & ~meas_reg;
      measure_clear  <= wr_hit & ~bus_req.wdata[`ISC_MEAS_BIT] & meas_reg;
      if (wr_hit && bus_req.wdata[`ISC_MEAS_BIT] && !meas_reg) begin
        measure_running <= 1'b1;
      end else if (offset_measure_done && !done_prev_reg) begin
        measure_running <= 1'b0;
      end
    end
  end

  assign start_offset_measure = meas_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  AST_FILL_WORD: assert property (fill_cmd.active |-> (fill_cmd.word[10:0] == 11'h000)
    && (fill_cmd.word[15:11] == fill_val_reg)) else $error("fill word layout wrong");
  AST_FILL_START: assert property (fill_start |=> fill_cmd.active && read_word[4])
    else $error("fill did not start");
  AST_FILL_UNARMED: assert property ((wr_hit && !block_fill_ready) |=> !fill_cmd.active)
    else $error("fill started while not armed");
  AST_FILL_LENGTH: assert property (fill_end |=> !fill_cmd.active ##0 finish_reg ##1 !finish_reg)
    else $error("fill did not end after two frames");
  AST_GO_CLEARS: assert property ($fell(fill_cmd.active) |-> !read_word[4])
    else $error("go bit still set after fill");
  AST_FILL_ABORT: assert property ((fill_cmd.active && !block_fill_ready) |=> !fill_cmd.active)
    else $error("fill not aborted");
  AST_STANDBY: assert property (##1 (serial_out_lanes_oe == {16{$past(lane_drive)}}))
    else $error("lane enables wrong");
  AST_LAUNCH: assert property ((wr_hit && bus_req.wdata[2] && !meas_reg)
    |=> measure_launch && measure_running ##1 !measure_launch) else $error("launch missing");
  AST_STOP: assert property ((measure_running && !measure_launch && offset_measure_done
    && !done_prev_reg && !wr_hit) |=> !measure_running) else $error("measure did not stop");
  AST_RATE: assert property (wr_hit |=> (serial_rate_select == $past(bus_req.wdata[1:0]))
    && (rate_reserved == (serial_rate_select == ISC_RATE_RSV))) else $error("rate field wrong");
  AST_CLEAR: assert property ((wr_hit && !bus_req.wdata[2] && meas_reg) |=> measure_clear)
    else $error("done clear missing");
  AST_RESET: assert property (@(posedge sys_clk) disable iff (1'b0) sys_rst |=>
    (read_word == 16'h0000) && !fill_cmd.active) else $error("reset value wrong");

  COV_FILL_DONE: cover property (fill_start ##[1:300] finish_reg);
  COV_FILL_ABORT: cover property (fill_cmd.active ##1 fill_abort);
  COV_MEASURE: cover property (measure_launch ##[1:300] !measure_running);

endmodule : isc_interface_setup

/* isc_consts.svh */
// Offsets, field positions, reset values and frame counts of the interface setup block
// Assumes inclusion by bare name from design files
`ifndef ISC_CONSTS_SVH
`define ISC_CONSTS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define ISC_ADDR_SETUP     8'h01
`define ISC_SETUP_RESET    16'h0000
`define ISC_READ_UNMAPPED  16'h0000

// ----------------------------------------
// Field positions of the setup register
// ----------------------------------------
`define ISC_FILL_VAL_MSB   9
`define ISC_FILL_VAL_LSB   5
`define ISC_GO_BIT         4
`define ISC_STBY_BIT       3
`define ISC_MEAS_BIT       2
`define ISC_RATE_MSB       1
`define ISC_RATE_LSB       0

// ----------------------------------------
// Timing in frames
// ----------------------------------------
`define ISC_FILL_FRAMES    2

`endif

/* isc_pkg.sv */
// Types shared by the interface setup block
// Assumes isc_consts.svh is on the include path
package isc_pkg;

  // Serial rate codes
  typedef enum logic [1:0] {
    ISC_RATE_2M  = 2'h0,
    ISC_RATE_4M  = 2'h1,
    ISC_RATE_8M  = 2'h2,
    ISC_RATE_RSV = 2'h3
  } isc_rate_type;

  // Block fill sequencer states
  typedef enum logic {
    FILL_IDLE,
    FILL_WRITE
  } isc_fill_state_type;

  // Parallel bus request, one cycle per access
  typedef struct packed {
    logic        sel;
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } isc_bus_req_type;

  // Connection memory block fill command
  typedef struct packed {
    logic        active;
    logic [15:0] word;
  } isc_fill_cmd_type;

endpackage : isc_pkg

/* isc_frame_partner.sv */
// Frame timing and offset measurement side facing the setup block
// Assumes the same sys_clk and synchronous reset as the block
module isc_frame_partner
  import isc_pkg::*;
#(
  parameter int FRAME_LEN   = 20, // Cycles per frame
  parameter int MEAS_FRAMES = 2   // Frames until an offset is found
)(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Measurement control from the block
  input  wire logic measure_launch,
  input  wire logic measure_clear,
  // Frame timing and status to the block
  output logic      frame_pulse,
  output logic      offset_measure_done
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] cnt_reg;      // Position within the frame
  logic [3:0] meas_cnt_reg; // Frames seen while measuring
  logic       busy_reg;     // Measurement in progress

  // Free running frame counter
  always_ff @(posedge sys_clk) begin
    if (sys_rst || cnt_reg == 8'(FRAME_LEN - 1)) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  // One pulse per frame, none during reset
  assign frame_pulse = (cnt_reg == 8'h00) && !sys_rst;

  // Offset measurement: done flag rises after a few frames
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      busy_reg            <= 1'b0;
      meas_cnt_reg        <= 4'h0;
      offset_measure_done <= 1'b0;
    end else if (measure_launch) begin
      busy_reg     <= 1'b1;
      meas_cnt_reg <= 4'h0;
    end else if (measure_clear) begin
      offset_measure_done <= 1'b0;
    end else if (busy_reg && frame_pulse) begin
      if (meas_cnt_reg == 4'(MEAS_FRAMES - 1)) begin
        offset_measure_done <= 1'b1;
        busy_reg            <= 1'b0;
      end else begin
        meas_cnt_reg <= meas_cnt_reg + 4'h1;
      end
    end
  end
endmodule : isc_frame_partner

/* tb_top.sv */
// Self-checking bench of the interface setup block
// Assumes isc_pkg and isc_consts.svh are compiled first
`include "isc_consts.svh"
module tb_top
  import isc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk, sys_rst, ready, pin, ack, rsv, meas, launch, clr, run, fin, fp, done;
  isc_bus_req_type  req;
  logic [15:0]      rdata, oe, m, d;
  isc_rate_type     rate;
  isc_fill_cmd_type fill;
  int               err_total, checks, cyc, n;

  isc_interface_setup DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus_req(req),
    .bus_rdata(rdata), .bus_ack(ack), .block_fill_ready(ready), .frame_pulse(fp),
    .offset_measure_done(done), .output_drive_pin(pin), .serial_out_lanes_oe(oe),
    .serial_rate_select(rate), .rate_reserved(rsv), .start_offset_measure(meas),
    .measure_launch(launch), .measure_clear(clr), .measure_running(run),
    .fill_cmd(fill), .fill_finish_pulse(fin));

  isc_frame_partner #(.FRAME_LEN(20), .MEAS_FRAMES(2)) far_end (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .measure_launch(launch), .measure_clear(clr),
    .frame_pulse(fp), .offset_measure_done(done));

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 6000) begin
      err_total++;
      results();
    end
  end

  task results;
    if (err_total == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // One bus access; returns in the answer cycle
  task acc(input logic w, input logic [7:0] a, input logic [15:0] dd);
    @(posedge sys_clk);
    #2 req = {1'b1, w, a, dd};
    @(posedge sys_clk);
    #2 req.sel = 1'b0;
    chk("ack", 16'h1, 16'(ack));
  endtask : acc

  task rd(input logic [7:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000);
    chk("rdata", e, rdata);
  endtask : rd

  task step(input int k);
    repeat (k) @(posedge sys_clk);
    #2;
  endtask : step

  initial begin
    req = '0; ready = 0; pin = 0; sys_rst = 1; err_total = 0; checks = 0; cyc = 0;
    void'($urandom(6568));
    step(8);
    sys_rst = 0;
    rd(8'h01, 16'h0000);
    chk("oe", 16'h0000, oe);
    rd(8'h07, 16'h0000);
    // Rate codes, standby and drive pin
    for (int r = 0; r < 3; r++) begin
      pin = 1'($urandom);
      d = {6'h00, 5'($urandom), 1'b0, 1'($urandom), 1'b0, 2'(r)};
      acc(1'b1, 8'h01, d);
      m = d;
      rd(8'h01, m);
      chk("rate", 16'(r), 16'(rate));
      chk("rsv", 16'(r == 3), 16'(rsv));
      step(4);
      chk("oe", {16{pin | m[3]}}, oe);
    end
    // Block fill to completion
    ready = 1;
    d = {6'h00, 5'($urandom), 5'h10};
    acc(1'b1, 8'h01, d);
    m = d & 16'h03ef;
    chk("active", 16'h1, 16'(fill.active));
    chk("word", {d[9:5], 11'h000}, fill.word);
    n = 0;
    for (int i = 0; i < 300 && fin !== 1'b1; i++) begin
      if (fp && fill.active) n++;
      step(1);
    end
    chk("frames", 16'(`ISC_FILL_FRAMES + 1), 16'(n));
    chk("fin", 16'h1, 16'(fin));
    rd(8'h01, m);
    // Abort by ready low, then by go cleared
    for (int k = 0; k < 2; k++) begin
      acc(1'b1, 8'h01, m | 16'h0010);
      step(3);
      if (k == 0) ready = 0;
      else acc(1'b1, 8'h01, m);
      step(2);
      chk("abort", 16'h0, 16'({fill.active, fin}));
      ready = 1;
    end
    // Start refused while not armed
    ready = 0;
    acc(1'b1, 8'h01, m | 16'h0010);
    chk("armed", 16'h0, 16'(fill.active));
    rd(8'h01, m);
    ready = 1;
    // Offset measurement launch, stop and clear
    m = m | 16'h0004;
    acc(1'b1, 8'h01, m);
    chk("launch", 16'h3, 16'({launch, run}));
    chk("meas", 16'h1, 16'(meas));
    for (int i = 0; i < 300 && run !== 1'b0; i++) step(1);
    chk("stop", 16'h1, 16'({run, done}));
    step(20);
    m = m & 16'hfffb;
    acc(1'b1, 8'h01, m);
    chk("clear", 16'h1, 16'(clr));
    step(1);
    chk("done", 16'h0, 16'(done));
    chk("meas", 16'h0, 16'(meas));
    // Second evaluation after the bit stayed low a full frame
    step(20);
    m = m | 16'h0004;
    acc(1'b1, 8'h01, m);
    chk("relaunch", 16'h3, 16'({launch, run}));
    results();
  end
endmodule : tb_top
